//--- rtl/mon_pkg.sv
// monitor source select package: timing, panel key layout, route types
// assumes a single 100 MHz clock and a synchronous power-up reset
package mon_pkg;

   // clock and time base
   localparam int CLK_HZ = 100_000_000;
   localparam int TICK_US = 1000;
   localparam int TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_US;

   // key filtering and hold detection, in milliseconds
   localparam int DEBOUNCE_MS = 5;
   localparam int DEB_TICKS = DEBOUNCE_MS * 1000 / TICK_US;
   localparam int HOLD_MS = 1000;
   localparam int HOLD_TICKS = HOLD_MS * 1000 / TICK_US;

   // analogue figures the switching stands for
   localparam int DIM_DB = 20;
   localparam int TONE_HZ = 1000;

   // default key counts
   localparam int N_IN_DEF = 8;
   localparam int N_OUT_DEF = 8;
   localparam int N_ROUTE_DEF = 4;

   // monitor source, gray coded in declaration order
   typedef enum logic [2:0] {
      MON_QUIET = 3'h0,
      MON_MAIN = 3'h1,
      MON_CENTRE = 3'h3,
      MON_THREE_WAY = 3'h2,
      MON_TAPE = 3'h6,
      MON_OUT_AFL = 3'h7,
      MON_IN_AFL = 3'h5,
      MON_IN_PFL = 3'h4
   } mon_src_t;

   // panel keys and switches, one bit each, 1 = pressed or down
   typedef struct packed {
      logic tape_return_source;
      logic main_stereo_source;
      logic centre_source;
      logic mono;
      logic local_mute;
      logic talk;
      logic clear_all;
      logic add_mode;
      logic after_fader_type;
      logic gen_tone;
      logic gen_route;
      logic gen_disable;
      logic ic_listen;
      logic ic_call;
      logic solo_in_place_mode;
   } mon_panel_t;

   // monitor switching decision
   typedef struct packed {
      mon_src_t src;
      logic mon_mono;
      logic local_mute;
      logic dim;
      logic wedge_mono;
      logic meter_listen;
      logic listen_stereo;
   } mon_route_t;

endpackage : mon_pkg

//--- rtl/mon_select.sv
// monitor source select: key filtering, listen selection and source priority
// assumes raw panel keys straight from pins, active high, bouncing freely
`timescale 1ns/1ns
module mon_select #(
   parameter int N_IN = mon_pkg::N_IN_DEF,
   parameter int N_OUT = mon_pkg::N_OUT_DEF,
   parameter int N_ROUTE = mon_pkg::N_ROUTE_DEF,
   parameter int TICK_CYCLES = mon_pkg::TICK_CYCLES,
   parameter int DEB_TICKS = mon_pkg::DEB_TICKS,
   parameter int HOLD_TICKS = mon_pkg::HOLD_TICKS
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic srst_i,
   // raw keys from the panel
   input wire logic [N_IN-1:0] in_key_i,
   input wire logic [N_OUT-1:0] out_key_i,
   input wire mon_pkg::mon_panel_t panel_i,
   input wire logic [N_ROUTE-1:0] talk_route_enable_i,
   // monitor decision and lamps
   output mon_pkg::mon_route_t route_o,
   output logic [N_IN-1:0] in_sel_o,
   output logic [N_OUT-1:0] out_sel_o,
   output logic clear_lamp_o,
   output logic solo_cleared_o,
   // generator and intercom
   output logic gen_tone_o,
   output logic [N_ROUTE-1:0] gen_to_out_o,
   output logic ic_listen_o,
   output logic call_lamp_o
);

   localparam int NP = $bits(mon_pkg::mon_panel_t);
   localparam int NL = N_IN + N_OUT;
   localparam int NK = NL + NP + N_ROUTE;
   localparam int TW = $clog2(TICK_CYCLES + 1);
   localparam int DW = $clog2(DEB_TICKS + 1);
   localparam int HW = $clog2(HOLD_TICKS + 1);

   // every check below runs on the one clock and rests during reset
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (srst_i);

   // refuse shapes the pairing and counters cannot serve
   generate
      if (N_OUT % 2 != 0 || N_IN < 1 || N_OUT < 2 || TICK_CYCLES < 2 || DEB_TICKS < 1 || HOLD_TICKS < 2) begin : g_bad
         $error("mon_select: unsupported parameter values");
      end
   endgenerate

   // millisecond enable from the system clock
   logic [TW-1:0] tick_cnt_q;
   logic tick_q;
   always_ff @(posedge clk_i) begin
      if (srst_i || tick_cnt_q == TW'(TICK_CYCLES - 1)) begin
         tick_cnt_q <= '0;
      end else begin
         tick_cnt_q <= tick_cnt_q + 1'b1;
      end
      tick_q <= !srst_i && tick_cnt_q == TW'(TICK_CYCLES - 1);
   end

   // two-flop synchroniser on every key
   logic [NK-1:0] raw, s1_q, s2_q, deb;
   assign raw = {talk_route_enable_i, panel_i, out_key_i, in_key_i};
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         s1_q <= '0;
         s2_q <= '0;
      end else begin
         s1_q <= raw;
         s2_q <= s1_q;
      end
   end

   // debounce: a level must stand through DEB_TICKS ticks in a row before it is believed
   genvar k;
   generate
      for (k = 0; k < NK; k++) begin : g_deb
         logic [DW-1:0] cnt_q;
         logic lvl_q;
         always_ff @(posedge clk_i) begin
            if (srst_i || s2_q[k] == lvl_q) begin
               cnt_q <= '0;
               if (srst_i) lvl_q <= 1'b0;
            end else if (tick_q) begin
               if (cnt_q == DW'(DEB_TICKS - 1)) begin
                  lvl_q <= s2_q[k];
                  cnt_q <= '0;
               end else begin
                  cnt_q <= cnt_q + 1'b1;
               end
            end
         end
         assign deb[k] = lvl_q;
      end
   endgenerate

   // filtered key groups and edges
   logic [NK-1:0] prev_q;
   logic [NL-1:0] lk, lpress, lrel;
   mon_pkg::mon_panel_t pnl, pnl_prev;
   logic [N_ROUTE-1:0] ren;
   always_ff @(posedge clk_i) begin
      if (srst_i) prev_q <= '0;
      else prev_q <= deb;
   end
   assign lk = deb[NL-1:0];
   assign lpress = deb[NL-1:0] & ~prev_q[NL-1:0];
   assign lrel = ~deb[NL-1:0] & prev_q[NL-1:0];
   assign pnl = deb[NL+NP-1:NL];
   assign pnl_prev = prev_q[NL+NP-1:NL];
   assign ren = deb[NK-1:NL+NP];

   logic [N_IN-1:0] in_press;
   logic [N_OUT-1:0] out_press;
   logic clr_press, gen_press;
   assign in_press = lpress[N_IN-1:0];
   assign out_press = lpress[NL-1:N_IN];
   assign clr_press = pnl.clear_all && !pnl_prev.clear_all;
   assign gen_press = pnl.gen_route && !pnl_prev.gen_route;

   // selection state, cleared by power-up reset
   logic [N_IN-1:0] in_sel_q, in_sel_d;
   logic [N_OUT-1:0] out_sel_q, out_sel_d, saved_q, saved_d;
   logic [NL-1:0] sel_all;
   assign sel_all = {out_sel_q, in_sel_q};

   // per-key hold timer and toggle memory
   logic [NL-1:0] long_q, tog_q;
   generate
      for (k = 0; k < NL; k++) begin : g_hold
         logic [HW-1:0] hcnt_q;
         always_ff @(posedge clk_i) begin
            if (srst_i || lpress[k]) begin
               hcnt_q <= '0;
               long_q[k] <= 1'b0;
               tog_q[k] <= !srst_i && sel_all[k];
            end else if (lk[k] && tick_q && !long_q[k]) begin
               hcnt_q <= hcnt_q + 1'b1;
               if (hcnt_q == HW'(HOLD_TICKS - 1)) long_q[k] <= 1'b1;
            end
         end
      end
   endgenerate

   // next selection; the order of the steps sets who wins
   always_comb begin
      in_sel_d = in_sel_q;
      out_sel_d = out_sel_q;
      saved_d = saved_q;
      // long hold is momentary; a short press on a lit key turns it off
      // split per group so no index ever runs past its vector
      for (int i = 0; i < N_IN; i++) begin
         if (lrel[i] && (long_q[i] || tog_q[i])) begin
            in_sel_d[i] = 1'b0;
         end
      end
      for (int j = 0; j < N_OUT; j++) begin
         if (lrel[N_IN+j] && (long_q[N_IN+j] || tog_q[N_IN+j])) begin
            out_sel_d[j] = 1'b0;
         end
      end
      if (|in_press) begin
         if (!pnl.add_mode) in_sel_d = '0;
         in_sel_d = in_sel_d | in_press;
         if (|out_sel_d) begin
            saved_d = out_sel_d;
            out_sel_d = '0;
         end
      end
      if (|out_press) begin
         if (!pnl.add_mode) out_sel_d = '0;
         out_sel_d = out_sel_d | out_press;
         in_sel_d = '0;
         saved_d = '0;
      end
      // last input gone: bring back the outputs it pushed aside
      if (|in_sel_q && in_sel_d == '0 && out_sel_d == '0) begin
         out_sel_d = saved_d;
         saved_d = '0;
      end
      // in solo mode the clear key belongs to the solo mix
      if (clr_press && !pnl.solo_in_place_mode) begin
         in_sel_d = '0;
         out_sel_d = '0;
         saved_d = '0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         in_sel_q <= '0;
         out_sel_q <= '0;
         saved_q <= '0;
      end else begin
         in_sel_q <= in_sel_d;
         out_sel_q <= out_sel_d;
         saved_q <= saved_d;
      end
   end

   // solo mix toggle from the clear key
   always_ff @(posedge clk_i) begin
      if (srst_i || !pnl.solo_in_place_mode) solo_cleared_o <= 1'b0;
      else if (clr_press) solo_cleared_o <= !solo_cleared_o;
   end

   // stereo output listen needs both keys of a pair
   logic pair_hit;
   always_comb begin
      pair_hit = 1'b0;
      for (int p = 0; p < N_OUT / 2; p++) begin
         if (out_sel_q[2*p] && out_sel_q[2*p+1]) pair_hit = 1'b1;
      end
   end

   // source priority, registered so every output leaves a flop
   mon_pkg::mon_route_t route_d;
   logic listen_on;
   assign listen_on = |in_sel_q || |out_sel_q;
   always_comb begin
      route_d = '0;
      if (|in_sel_q) begin
         route_d.src = pnl.after_fader_type ? mon_pkg::MON_IN_AFL : mon_pkg::MON_IN_PFL;
         route_d.listen_stereo = pnl.after_fader_type;
      end else if (|out_sel_q) begin
         route_d.src = mon_pkg::MON_OUT_AFL;
         route_d.listen_stereo = pair_hit;
      end else if (pnl.tape_return_source) begin
         route_d.src = mon_pkg::MON_TAPE;
      end else if (pnl.main_stereo_source && pnl.centre_source) begin
         route_d.src = mon_pkg::MON_THREE_WAY;
      end else if (pnl.main_stereo_source) begin
         route_d.src = mon_pkg::MON_MAIN;
      end else if (pnl.centre_source) begin
         route_d.src = mon_pkg::MON_CENTRE;
      end else begin
         route_d.src = mon_pkg::MON_QUIET;
      end
      // mono on the monitor only; the meters keep their own feed
      route_d.mon_mono = pnl.mono || route_d.src == mon_pkg::MON_CENTRE
                         || (listen_on && !route_d.listen_stereo);
      route_d.local_mute = pnl.local_mute;
      route_d.dim = pnl.talk;
      route_d.wedge_mono = route_d.src == mon_pkg::MON_TAPE;
      route_d.meter_listen = listen_on;
   end

   // registered outputs
   logic gen_latch_q;
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         route_o <= '0;
         clear_lamp_o <= 1'b0;
         gen_latch_q <= 1'b0;
         gen_tone_o <= 1'b0;
         gen_to_out_o <= '0;
         ic_listen_o <= 1'b0;
         call_lamp_o <= 1'b0;
      end else begin
         route_o <= route_d;
         clear_lamp_o <= listen_on;
         if (gen_press) gen_latch_q <= !gen_latch_q;
         gen_tone_o <= pnl.gen_tone;
         gen_to_out_o <= (gen_latch_q && !pnl.gen_disable) ? ren : '0;
         ic_listen_o <= pnl.ic_listen;
         call_lamp_o <= pnl.ic_call;
      end
   end
   assign in_sel_o = in_sel_q;
   assign out_sel_o = out_sel_q;

   // checks on the switching decisions
   quiet_monitor_a: assert property (!listen_on && !pnl.tape_return_source && !pnl.main_stereo_source
      && !pnl.centre_source |=> route_o.src == mon_pkg::MON_QUIET) else $error("monitor not quiet");
   input_first_a: assert property (|in_sel_q |=> route_o.src inside {mon_pkg::MON_IN_PFL,
      mon_pkg::MON_IN_AFL}) else $error("input listen lost priority");
   output_second_a: assert property (!(|in_sel_q) && |out_sel_q |=> route_o.src == mon_pkg::MON_OUT_AFL)
      else $error("output listen lost priority");
   output_cancels_a: assert property (|out_press && !clr_press |=> in_sel_q == '0 && out_sel_q != '0)
      else $error("output press kept inputs");
   input_overrides_a: assert property (|in_press && |out_sel_q && !(|out_press) && !clr_press
      |=> out_sel_q == '0 && saved_q != '0) else $error("input press kept outputs");
   auto_cancel_a: assert property (!pnl.add_mode && |in_press && !(|out_press) && !clr_press
      |=> in_sel_q == $past(in_press)) else $error("auto cancel failed");
   clear_all_a: assert property (clr_press && !pnl.solo_in_place_mode |=> !listen_on ##1 !clear_lamp_o)
      else $error("clear all left a listen");
   lamp_follow_a: assert property (listen_on |=> clear_lamp_o) else $error("clear lamp dark");
   talk_dim_a: assert property (pnl.talk |=> route_o.dim) else $error("talk did not dim");
   tape_meter_a: assert property (route_o.src == mon_pkg::MON_TAPE |-> !route_o.meter_listen
      && route_o.wedge_mono) else $error("tape return metered");
   gen_block_a: assert property (pnl.gen_disable |=> gen_to_out_o == '0) else $error("generator leaked");

endmodule : mon_select

//--- verif/mon_panel_sw.sv
// panel switch model: raw keys and levers as the operator works them
// assumes the bench calls its tasks; every change lands 1 ns after a clock edge
`timescale 1ns/1ns
module mon_panel_sw (
   // clock
   input wire logic clk_i,
   // raw panel levels
   output logic [7:0] in_key_o,
   output logic [7:0] out_key_o,
   output mon_pkg::mon_panel_t panel_o,
   output logic [3:0] route_en_o
);
   // all keys up and levers flush at power-up
   initial begin
      in_key_o = 8'h00;
      out_key_o = 8'h00;
      panel_o = '0;
      route_en_o = 4'h0;
   end

   // press one listen key for len clocks, then leave time for the filter to settle
   task automatic tap(input logic sel_out, input int idx, input int len);
      @(posedge clk_i);
      #1;
      if (sel_out) begin
         out_key_o[idx] = 1'b1;
      end else begin
         in_key_o[idx] = 1'b1;
      end
      repeat (len) @(posedge clk_i);
      #1;
      if (sel_out) begin
         out_key_o[idx] = 1'b0;
      end else begin
         in_key_o[idx] = 1'b0;
      end
      repeat (20) @(posedge clk_i);
      #1;
   endtask : tap

   // move levers; 20 clocks covers sync, two whole debounce ticks and the output stages
   task automatic set_panel(input mon_pkg::mon_panel_t p, input logic [3:0] en);
      @(posedge clk_i);
      #1;
      panel_o = p;
      route_en_o = en;
      repeat (20) @(posedge clk_i);
      #1;
   endtask : set_panel
endmodule : mon_panel_sw

//--- verif/tb_mon_select.sv
// bench for the monitor source select: table of source keys, then listen cases
// assumes short sim timing: 4-clock tick, 2-tick debounce, 8-tick hold
// two debounce ticks so a 2-clock bounce can never straddle a whole window
`timescale 1ns/1ns
module tb_mon_select;
   typedef struct packed {
      logic [5:0] keys;
      logic [8:0] exp;
   } mon_row_t;
   logic clk_i;
   logic srst_i;
   logic [7:0] in_key;
   logic [7:0] out_key;
   mon_pkg::mon_panel_t panel;
   logic [3:0] route_en;
   mon_pkg::mon_route_t route_o;
   logic [7:0] in_sel_o;
   logic [7:0] out_sel_o;
   logic clear_lamp_o;
   logic solo_cleared_o;
   logic gen_tone_o;
   logic [3:0] gen_to_out_o;
   logic ic_listen_o;
   logic call_lamp_o;
   int mismatches;
   int n_compared;
   int cyc;
   mon_pkg::mon_panel_t pn;
   // keys are {tape, main, centre, mono, mute, talk}; exp is the whole route word
   mon_row_t rows [7] = '{
      '{6'b000000, {mon_pkg::MON_QUIET, 6'b000000}},
      '{6'b010000, {mon_pkg::MON_MAIN, 6'b000000}},
      '{6'b001000, {mon_pkg::MON_CENTRE, 6'b100000}},
      '{6'b011000, {mon_pkg::MON_THREE_WAY, 6'b000000}},
      '{6'b111000, {mon_pkg::MON_TAPE, 6'b000100}},
      '{6'b010100, {mon_pkg::MON_MAIN, 6'b100000}},
      '{6'b010011, {mon_pkg::MON_MAIN, 6'b011000}}};

   // free-running 100 MHz clock
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   mon_panel_sw u_sw (.clk_i(clk_i), .in_key_o(in_key), .out_key_o(out_key), .panel_o(panel),
      .route_en_o(route_en));

   mon_select #(.TICK_CYCLES(4), .DEB_TICKS(2), .HOLD_TICKS(8)) dut_u (
      .clk_i(clk_i), .srst_i(srst_i), .in_key_i(in_key), .out_key_i(out_key), .panel_i(panel),
      .talk_route_enable_i(route_en), .route_o(route_o), .in_sel_o(in_sel_o), .out_sel_o(out_sel_o),
      .clear_lamp_o(clear_lamp_o), .solo_cleared_o(solo_cleared_o), .gen_tone_o(gen_tone_o),
      .gen_to_out_o(gen_to_out_o), .ic_listen_o(ic_listen_o), .call_lamp_o(call_lamp_o));

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask : check

   task automatic complete_run();
      if (mismatches == 0 && n_compared > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : complete_run

   // hang guard, far beyond the thousand or so clocks the sequence needs
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         mismatches++;
         complete_run();
      end
   end

   initial begin
      mismatches = 0;
      n_compared = 0;
      pn = '0;
      srst_i = 1'b1;
      repeat (16) @(posedge clk_i);
      #1;
      srst_i = 1'b0;
      @(posedge clk_i);
      #1;
      check({route_o, in_sel_o, out_sel_o, clear_lamp_o}, 32'h0);
      // source key table
      foreach (rows[i]) begin
         {pn.tape_return_source, pn.main_stereo_source, pn.centre_source, pn.mono, pn.local_mute, pn.talk} = rows[i].keys;
         u_sw.set_panel(pn, 4'h0);
         check(route_o, rows[i].exp);
      end
      {pn.tape_return_source, pn.main_stereo_source, pn.centre_source, pn.mono, pn.local_mute, pn.talk} = 6'b010000;
      u_sw.set_panel(pn, 4'h0);
      // output listens, auto-cancel then add mode
      u_sw.tap(1'b1, 2, 20);
      check(out_sel_o, 32'h04);
      check(route_o, {mon_pkg::MON_OUT_AFL, 6'b100010});
      check(clear_lamp_o, 1'b1);
      u_sw.tap(1'b1, 3, 20);
      check(out_sel_o, 32'h08);
      pn.add_mode = 1'b1;
      u_sw.set_panel(pn, 4'h0);
      u_sw.tap(1'b1, 2, 20);
      check(out_sel_o, 32'h0c);
      check(route_o, {mon_pkg::MON_OUT_AFL, 6'b000011});
      // input listen overrides outputs, a second tap turns it off and restores them
      u_sw.tap(1'b0, 0, 20);
      check({in_sel_o, out_sel_o}, 32'h0100);
      check(route_o.src, mon_pkg::MON_IN_PFL);
      u_sw.tap(1'b0, 0, 20);
      check({in_sel_o, out_sel_o}, 32'h000c);
      check(route_o.src, mon_pkg::MON_OUT_AFL);
      // output press cancels inputs for good, in add mode too
      u_sw.tap(1'b0, 1, 20);
      u_sw.tap(1'b1, 0, 20);
      check({in_sel_o, out_sel_o}, 32'h0001);
      u_sw.tap(1'b1, 0, 20);
      check({in_sel_o, out_sel_o}, 32'h0000);
      check(route_o.src, mon_pkg::MON_MAIN);
      // auto-cancel on inputs, stereo after-fader type, then clear-all
      pn.add_mode = 1'b0;
      pn.after_fader_type = 1'b1;
      u_sw.set_panel(pn, 4'h0);
      u_sw.tap(1'b0, 3, 20);
      u_sw.tap(1'b0, 5, 20);
      check(in_sel_o, 32'h20);
      check(route_o.src, mon_pkg::MON_IN_AFL);
      pn.clear_all = 1'b1;
      u_sw.set_panel(pn, 4'h0);
      pn.clear_all = 1'b0;
      u_sw.set_panel(pn, 4'h0);
      check({in_sel_o, out_sel_o, clear_lamp_o}, 32'h0);
      // held key acts momentarily, a bounce is ignored
      u_sw.tap(1'b0, 4, 60);
      check(in_sel_o, 32'h00);
      u_sw.tap(1'b0, 6, 2);
      check(in_sel_o, 32'h00);
      // solo mode: clear-all toggles the solo mix and spares listens
      pn.solo_in_place_mode = 1'b1;
      u_sw.set_panel(pn, 4'h0);
      u_sw.tap(1'b0, 0, 20);
      pn.clear_all = 1'b1;
      u_sw.set_panel(pn, 4'h0);
      pn.clear_all = 1'b0;
      u_sw.set_panel(pn, 4'h0);
      check({in_sel_o, solo_cleared_o}, 32'h3);
      pn.solo_in_place_mode = 1'b0;
      u_sw.set_panel(pn, 4'h0);
      check(solo_cleared_o, 1'b0);
      // mid-run reset drops the live selection
      srst_i = 1'b1;
      repeat (2) @(posedge clk_i);
      #1;
      srst_i = 1'b0;
      repeat (2) @(posedge clk_i);
      #1;
      check({in_sel_o, clear_lamp_o}, 32'h0);
      // generator select, route latch and disable
      pn.gen_tone = 1'b1;
      pn.gen_route = 1'b1;
      u_sw.set_panel(pn, 4'h5);
      pn.gen_route = 1'b0;
      u_sw.set_panel(pn, 4'h5);
      check({gen_tone_o, gen_to_out_o}, 32'h15);
      pn.gen_disable = 1'b1;
      u_sw.set_panel(pn, 4'h5);
      check(gen_to_out_o, 32'h0);
      pn.gen_disable = 1'b0;
      u_sw.set_panel(pn, 4'h5);
      check(gen_to_out_o, 32'h5);
      // intercom gate and call lamp
      pn.ic_listen = 1'b1;
      pn.ic_call = 1'b1;
      u_sw.set_panel(pn, 4'h5);
      check({ic_listen_o, call_lamp_o}, 32'h3);
      // call lamp only while held; noise is the other generator choice
      pn.ic_call = 1'b0;
      pn.gen_tone = 1'b0;
      u_sw.set_panel(pn, 4'h5);
      check({gen_tone_o, ic_listen_o, call_lamp_o}, 32'h2);
      complete_run();
   end
endmodule : tb_mon_select
